/* File: gpc_host_model.sv */
// Host model: two-wire bus master with register write and read tasks.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module gpc_host_model (
	// Clock
	input  wire logic clk,
	// Bus lines, 1 releases the line
	output logic      scl,
	output logic      sda,
	input  wire logic sda_w
);
	// ==========================================================
	// Bit timing: 4 clk per half period, SCL stands high between frames
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic half();
		repeat (4) @(negedge clk);
	endtask : half

	// Long setup so a late ack release never looks like a stop
	task automatic start_cond();
		@(negedge clk);
		sda = 1'b1;
		half();
		half();
		scl = 1'b1;
		half();
		sda = 1'b0;
		half();
		scl = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		@(negedge clk);
		sda = 1'b0;
		repeat (3) @(negedge clk);
		scl = 1'b1;
		half();
		sda = 1'b1;
		half();
	endtask : stop_cond

	// Data moves one clk after SCL falls; the reply is taken at the end of SCL high
	task automatic bit_io(input logic b, output logic r);
		@(negedge clk);
		sda = b;
		repeat (3) @(negedge clk);
		scl = 1'b1;
		half();
		r   = sda_w;
		scl = 1'b0;
	endtask : bit_io

	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(ack_in, ack);
	endtask : xfer

	task automatic reg_write(input logic [6:0] dev, input logic [7:0] ptr, dat,
		output logic nak);
		logic [7:0] rx;
		logic       a0, a1, a2;
		start_cond();
		xfer({dev, 1'b0}, 1'b1, rx, a0);
		xfer(ptr, 1'b1, rx, a1);
		xfer(dat, 1'b1, rx, a2);
		stop_cond();
		nak = a0 | a1 | a2;
	endtask : reg_write

	task automatic reg_read(input logic [6:0] dev, input logic [7:0] ptr,
		output logic [7:0] dat, output logic nak);
		logic [7:0] rx;
		logic       a0, a1, a2, a3;
		start_cond();
		xfer({dev, 1'b0}, 1'b1, rx, a0);
		xfer(ptr, 1'b1, rx, a1);
		start_cond();
		xfer({dev, 1'b1}, 1'b1, rx, a2);
		xfer(8'hFF, 1'b1, dat, a3);
		stop_cond();
		nak = a0 | a1 | a2;
	endtask : reg_read
endmodule : gpc_host_model

`default_nettype wire

/* File: gpc_i2c_slave.sv */
// Byte-level two-wire serial slave: address, register pointer, data bytes.
// Assumes scl and sda arrive already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none

module gpc_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = gpc_pkg::I2C_DEV_ADDR
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rstn,
	// Synchronised bus lines
	input  wire logic                      scl_s,
	input  wire logic                      sda_s,
	output logic                           sda_oe_n,
	// Register side
	output logic [7:0]                     reg_addr,
	output logic                           wr_en,
	output logic [gpc_pkg::REG_W-1:0]      wr_data,
	input  wire logic [gpc_pkg::REG_W-1:0] rd_data
);
	import gpc_pkg::*;

	typedef struct packed {
		gpc_i2c_e   state;
		logic       scl_q;
		logic       sda_q;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic       rw;
		logic [1:0] phase;
		logic [7:0] ptr;
		logic       drive;
		logic       wr_en;
		logic [7:0] wr_data;
	} gpc_i2c_s;

	gpc_i2c_s st;
	gpc_i2c_s next_st;
	logic     rise;
	logic     fall;
	logic     start;
	logic     stop;

	assign rise  = scl_s & ~st.scl_q;
	assign fall  = ~scl_s & st.scl_q;
	assign start = st.scl_q & scl_s & st.sda_q & ~sda_s;
	assign stop  = st.scl_q & scl_s & ~st.sda_q & sda_s;

	always_comb
	begin
		next_st       = st;
		next_st.wr_en = 1'b0;
		next_st.scl_q = scl_s;
		next_st.sda_q = sda_s;
		if (start)
		begin
			next_st.state = I2C_RX;
			next_st.cnt   = 4'h0;
			next_st.phase = 2'h0;
			next_st.drive = 1'b0;
		end
		else if (stop)
		begin
			next_st.state = I2C_IDLE;
			next_st.drive = 1'b0;
		end
		else
		begin
			case (st.state)
				I2C_RX:
				begin
					if (rise && st.cnt < I2C_BITS)
					begin
						next_st.sh  = {st.sh[6:0], sda_s};
						next_st.cnt = st.cnt + 4'h1;
					end
					else if (fall && st.cnt == I2C_BITS)
					begin
						next_st.cnt   = 4'h0;
						next_st.state = I2C_ACK;
						next_st.drive = 1'b1;
						if (st.phase == 2'h0)
						begin
							next_st.rw = st.sh[0];
							// Foreign address: stay off the bus until the next start
							if (st.sh[7:1] != DEV_ADDR)
							begin
								next_st.state = I2C_IDLE;
								next_st.drive = 1'b0;
							end
						end
						else if (st.phase == 2'h1)
							next_st.ptr = st.sh;
						else
						begin
							next_st.wr_en   = 1'b1;
							next_st.wr_data = st.sh;
						end
					end
				end
				I2C_ACK:
				begin
					if (fall)
					begin
						next_st.drive = 1'b0;
						if (st.phase == 2'h0)
							next_st.phase = st.rw ? 2'h2 : 2'h1;
						else if (st.phase == 2'h1)
							next_st.phase = 2'h2;
						else if (!st.rw)
							next_st.ptr = st.ptr + 8'h01;
						if (st.rw)
						begin
							next_st.state = I2C_TX;
							next_st.sh    = rd_data;
							next_st.drive = ~rd_data[7];
							next_st.cnt   = 4'h1;
						end
						else
							next_st.state = I2C_RX;
					end
				end
				I2C_TX:
				begin
					if (fall)
					begin
						if (st.cnt == I2C_BITS)
						begin
							next_st.drive = 1'b0;
							next_st.state = I2C_TXACK;
						end
						else
						begin
							next_st.drive = ~st.sh[6];
							next_st.sh    = {st.sh[6:0], 1'b0};
							next_st.cnt   = st.cnt + 4'h1;
						end
					end
				end
				I2C_TXACK:
				begin
					// Master ack: reuse the ack state to load the next byte on the fall
					if (rise)
					begin
						if (sda_s)
							next_st.state = I2C_IDLE;
						else
						begin
							next_st.ptr   = st.ptr + 8'h01;
							next_st.state = I2C_ACK;
						end
					end
				end
				default:
				begin
					next_st.drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st       <= '0;
			st.state <= I2C_IDLE;
			st.scl_q <= 1'b1;
			st.sda_q <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign sda_oe_n = ~st.drive;
	assign reg_addr = st.ptr;
	assign wr_en    = st.wr_en;
	assign wr_data  = st.wr_data;

endmodule : gpc_i2c_slave

`default_nettype wire

/* File: gpc_pkg.sv */
// Constants shared by the general-purpose pin control block.
// Assumes a 125 MHz core clock and byte-wide registers on a two-wire serial bus.
`default_nettype none

package gpc_pkg;

	// ==========================================================
	// Register map
	localparam int          REG_W       = 8;
	localparam logic [7:0]  ADDR_PIN12  = 8'h1B;
	localparam logic [7:0]  ADDR_PIN3   = 8'h1C;
	localparam logic [7:0]  RST_PIN12   = 8'h00;
	localparam logic [7:0]  RST_PIN3    = 8'h00;

	// ==========================================================
	// Field positions, pin12_control
	localparam int B_DIR2   = 7;
	localparam int B_DIR1   = 6;
	localparam int B_OUT2   = 5;
	localparam int B_OUT1   = 4;
	localparam int B_POL2   = 3;
	localparam int B_POL1   = 2;
	localparam int B_SBY1   = 1;
	localparam int B_BUCKA1 = 0;

	// ==========================================================
	// Field positions, pin3_misc_control
	localparam int B_DIR3   = 7;
	localparam int B_OUT3   = 6;
	localparam int B_AUXREG = 5;
	localparam int B_CHGV   = 4;
	localparam int B_IRQ2   = 2;
	localparam int B_IRQ1   = 1;
	localparam int B_BUCKB2 = 0;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int INT_PULSE_NS  = 1000;
	localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_CNT_W     = 8;

	// ==========================================================
	// Serial bus
	// Device address value is arbitrary
	localparam logic [6:0] I2C_DEV_ADDR = 7'h2A;
	localparam logic [3:0] I2C_BITS     = 4'h8;

	typedef enum {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_TXACK} gpc_i2c_e;

endpackage : gpc_pkg

`default_nettype wire

/* File: gpc_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps
`default_nettype none

module gpc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	import gpc_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gpc_sync_s;

	gpc_sync_s st;
	gpc_sync_s next_st;

	always_comb
	begin
		next_st    = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.s2;

endmodule : gpc_sync

`default_nettype wire

/* File: gpc_top.sv */
// Control registers for three general-purpose pins and pin-driven converter controls.
// Assumes pins, scl and sda are asynchronous; the pad resolves open-drain levels.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (RL1) Register pin12_control sits at 0x1B, all eight bits read/write.
// (RL2) Register pin3_misc_control sits at 0x1C, all eight bits read/write.
// (RL3) Direction bits: 0x1B B7 pin two, B6 pin one, 0x1C B7 pin three.
// (RL4) 0x1B B5 sets pin two output level; ignored while input.
// (RL5) 0x1B B4 sets pin one output level; ignored while input.
// (RL6) 0x1B B3: 0 rising edge/low level, 1 falling edge/high level, pin two.
// (RL7) 0x1B B2: 0 rising edge/low level, 1 falling edge/high level, pin one.
// (RL8) 0x1B B1 lets pin one level control standby of both bucks.
// (RL9) 0x1B B0 lets pin one level switch buck a.
// (RL10) 0x1C B6 sets pin three output level.
// (RL11) 0x1C B5 switches the auxiliary regulator on or off.
// (RL12) 0x1C B4 selects charge voltage 4.20 V or 4.36 V; B3 unused.
// (RL13) 0x1C B2 lets a selected pin two edge pulse the interrupt low.
// (RL14) 0x1C B1 lets a selected pin one edge pulse the interrupt low.
// (RL15) 0x1C B0 lets pin two level switch buck b.
// (RL16) Sampled levels of all three pins go to the standby register.
// (RL17) Output level 1 releases the pin; level 0 pulls it low.
// (RL18) A qualifying edge pulses the interrupt high-low-high.
// (RL19) Both registers load fixed defaults on reset.
// (RL20) Edges are found on synchronised samples, one event per transition.
module gpc_top #(
	parameter logic [6:0] DEV_ADDR = gpc_pkg::I2C_DEV_ADDR
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Serial bus
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// General-purpose pins
	input  wire logic       gp_pin_one_in,
	output logic            gp_pin_one_out,
	output logic            gp_pin_one_oe_n,
	input  wire logic       gp_pin_two_in,
	output logic            gp_pin_two_out,
	output logic            gp_pin_two_oe_n,
	input  wire logic       gp_pin_three_in,
	output logic            gp_pin_three_out,
	output logic            gp_pin_three_oe_n,
	// Host interrupt
	output logic            irq_n,
	// Converter and misc controls
	output logic            buck_a_pin_on,
	output logic            buck_b_pin_on,
	output logic            buck_standby_pin_req,
	output logic            aux_regulator_enable,
	output logic            charge_voltage_select,
	// Pin levels for buck_standby_reg bits 5..7
	output logic [2:0]      pin_levels
);
	import gpc_pkg::*;

	// ==========================================================
	// Reset release
	logic [1:0] rst_ff;
	logic       rstn_sync;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rst_ff <= 2'b00;
		else
			rst_ff <= {rst_ff[0], 1'b1};
	end

	assign rstn_sync = rst_ff[1];

	// ==========================================================
	// Input synchronisers and serial slave
	logic [4:0]       sync_q;
	logic [2:0]       pin_s;
	logic [7:0]       reg_addr;
	logic             wr_en;
	logic [REG_W-1:0] wr_data;
	logic [REG_W-1:0] rd_data;

	gpc_sync #(
		.W (5)
	) u_sync (
		.clk  (clk),
		.rstn (rstn_sync),
		.d    ({sda_in, scl_in, gp_pin_three_in, gp_pin_two_in, gp_pin_one_in}),
		.q    (sync_q)
	);

	assign pin_s = sync_q[2:0];

	gpc_i2c_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_slave (
		.clk      (clk),
		.rstn     (rstn_sync),
		.scl_s    (sync_q[3]),
		.sda_s    (sync_q[4]),
		.sda_oe_n (sda_oe_n),
		.reg_addr (reg_addr),
		.wr_en    (wr_en),
		.wr_data  (wr_data),
		.rd_data  (rd_data)
	);

	assign sda_out = 1'b0;

	// ==========================================================
	// State
	typedef struct packed {
		logic [REG_W-1:0]     reg12;
		logic [REG_W-1:0]     reg3;
		logic [2:0]           pin_q;
		logic [INT_CNT_W-1:0] int_cnt;
		logic                 irq_n;
		logic [2:0]           oe_n;
		logic                 buck_a;
		logic                 buck_b;
		logic                 sby;
		logic [2:0]           levels;
	} gpc_top_s;

	gpc_top_s st;
	gpc_top_s next_st;
	logic     ev1;
	logic     ev2;

	// Unmapped pointers read as zero
	function automatic logic [REG_W-1:0] reg_read(input logic [7:0] a,
		input logic [REG_W-1:0] r12, input logic [REG_W-1:0] r3);
		if (a == ADDR_PIN12)
			return r12;
		else if (a == ADDR_PIN3)
			return r3;
		else
			return '0;
	endfunction : reg_read

	// Level control is active when the pin is an input and level matches polarity
	function automatic logic level_hit(input logic en, input logic dir,
		input logic pin, input logic pol);
		return en & ~dir & ~(pin ^ pol);
	endfunction : level_hit

	assign rd_data = reg_read(reg_addr, st.reg12, st.reg3); // see RL1 // see RL2

	// Polarity 0 picks the rising edge, 1 the falling edge
	assign ev1 = ~st.reg12[B_DIR1] & st.reg3[B_IRQ1]
		& (st.reg12[B_POL1] ? (st.pin_q[0] & ~pin_s[0])
			: (~st.pin_q[0] & pin_s[0])); // see RL7 // see RL14 // see RL20
	assign ev2 = ~st.reg12[B_DIR2] & st.reg3[B_IRQ2]
		& (st.reg12[B_POL2] ? (st.pin_q[1] & ~pin_s[1])
			: (~st.pin_q[1] & pin_s[1])); // see RL6 // see RL13 // see RL20

	always_comb
	begin
		next_st       = st;
		next_st.pin_q = pin_s;
		if (wr_en)
		begin
			if (reg_addr == ADDR_PIN12)
				next_st.reg12 = wr_data; // see RL1
			else if (reg_addr == ADDR_PIN3)
				next_st.reg3 = wr_data; // see RL2 // see RL12
		end
		// A new edge during a pulse restarts it rather than being lost
		if (ev1 || ev2)
		begin
			next_st.int_cnt = INT_CNT_W'(INT_PULSE_CYC); // see RL18
			next_st.irq_n   = 1'b0;
		end
		else if (st.int_cnt != '0)
		begin
			next_st.int_cnt = st.int_cnt - 1'b1;
			next_st.irq_n   = (st.int_cnt == INT_CNT_W'(1)); // see RL18
		end
		// Open drain: only a low level is ever driven
		next_st.oe_n[0] = ~(st.reg12[B_DIR1] & ~st.reg12[B_OUT1]); // see RL3 // see RL5 // see RL17
		next_st.oe_n[1] = ~(st.reg12[B_DIR2] & ~st.reg12[B_OUT2]); // see RL3 // see RL4 // see RL17
		next_st.oe_n[2] = ~(st.reg3[B_DIR3] & ~st.reg3[B_OUT3]); // see RL3 // see RL10 // see RL17
		next_st.buck_a  = level_hit(st.reg12[B_BUCKA1], st.reg12[B_DIR1],
			pin_s[0], st.reg12[B_POL1]); // see RL9
		next_st.sby     = level_hit(st.reg12[B_SBY1], st.reg12[B_DIR1],
			pin_s[0], st.reg12[B_POL1]); // see RL8
		next_st.buck_b  = level_hit(st.reg3[B_BUCKB2], st.reg12[B_DIR2],
			pin_s[1], st.reg12[B_POL2]); // see RL15
		next_st.levels  = pin_s; // see RL16
	end

	always_ff @(posedge clk or negedge rstn_sync)
	begin
		if (!rstn_sync)
		begin
			st       <= '0;
			st.reg12 <= RST_PIN12; // see RL19
			st.reg3  <= RST_PIN3; // see RL19
			st.irq_n <= 1'b1;
			st.oe_n  <= 3'b111;
		end
		else
			st <= next_st;
	end

	// ==========================================================
	// Outputs
	assign gp_pin_one_out        = 1'b0;
	assign gp_pin_two_out        = 1'b0;
	assign gp_pin_three_out      = 1'b0;
	assign gp_pin_one_oe_n       = st.oe_n[0];
	assign gp_pin_two_oe_n       = st.oe_n[1];
	assign gp_pin_three_oe_n     = st.oe_n[2];
	assign irq_n                 = st.irq_n;
	assign buck_a_pin_on         = st.buck_a;
	assign buck_b_pin_on         = st.buck_b;
	assign buck_standby_pin_req  = st.sby;
	assign aux_regulator_enable  = st.reg3[B_AUXREG]; // see RL11
	assign charge_voltage_select = st.reg3[B_CHGV]; // see RL12
	assign pin_levels            = st.levels;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn_sync);

	sequence seq_wr12;
		wr_en && reg_addr == ADDR_PIN12;
	endsequence

	sequence seq_wr3;
		wr_en && reg_addr == ADDR_PIN3;
	endsequence

	sequence seq_edge_one;
		!st.reg12[B_DIR1] && st.reg3[B_IRQ1] && st.reg12[B_POL1]
			&& $past(pin_s[0]) && !pin_s[0];
	endsequence

	sequence seq_edge_two;
		!st.reg12[B_DIR2] && st.reg3[B_IRQ2] && !st.reg12[B_POL2]
			&& !$past(pin_s[1]) && pin_s[1];
	endsequence

	chk_reg12_write: assert property (seq_wr12 |=> st.reg12 == $past(wr_data)) // see RL1
		else $error("pin12_control not loaded");
	chk_reg3_write: assert property (seq_wr3 |=> st.reg3 == $past(wr_data)) // see RL2
		else $error("pin3_misc_control not loaded");
	chk_reg_readback: assert property (seq_wr3 ##1 reg_addr == ADDR_PIN3 // see RL2
		|-> rd_data == $past(wr_data))
		else $error("register readback mismatch");
	chk_reg12_readback: assert property (seq_wr12 ##1 reg_addr == ADDR_PIN12 // see RL1
		|-> rd_data == $past(wr_data))
		else $error("pin12_control readback mismatch");
	// Drive and level outputs are registered, so they are held against last cycle's state
	chk_pin_one_drive: assert property (1'b1 |=> gp_pin_one_oe_n // see RL5
		== !($past(st.reg12[B_DIR1]) && !$past(st.reg12[B_OUT1])))
		else $error("pin one drive wrong");
	chk_pin_two_drive: assert property (1'b1 |=> gp_pin_two_oe_n // see RL4
		== !($past(st.reg12[B_DIR2]) && !$past(st.reg12[B_OUT2])))
		else $error("pin two drive wrong");
	chk_pin_three_drive: assert property (1'b1 |=> gp_pin_three_oe_n // see RL10
		== !($past(st.reg3[B_DIR3]) && !$past(st.reg3[B_OUT3])))
		else $error("pin three drive wrong");
	chk_irq_pin_one: assert property (seq_edge_one |=> !irq_n) // see RL14
		else $error("pin one falling edge gave no interrupt");
	chk_irq_pin_two: assert property (seq_edge_two |=> !irq_n) // see RL13
		else $error("pin two rising edge gave no interrupt");
	chk_irq_width: assert property ($fell(irq_n) |-> (!irq_n)[*8]) // see RL18
		else $error("interrupt pulse too short");
	chk_irq_release: assert property (st.int_cnt == INT_CNT_W'(1) && !ev1 && !ev2 // see RL18
		|=> irq_n)
		else $error("interrupt not released");
	chk_irq_rise: assert property ($rose(irq_n) |-> $past(st.int_cnt) == INT_CNT_W'(1)) // see RL18
		else $error("interrupt released early");
	chk_irq_masked: assert property ((st.reg12[B_DIR1] || !st.reg3[B_IRQ1]) // see RL14
		&& (st.reg12[B_DIR2] || !st.reg3[B_IRQ2]) && st.int_cnt == '0 |=> irq_n)
		else $error("interrupt from a masked or output pin");
	chk_buck_a_level: assert property (1'b1 |=> buck_a_pin_on // see RL9
		== ($past(st.reg12[B_BUCKA1]) && !$past(st.reg12[B_DIR1])
		&& $past(pin_s[0]) == $past(st.reg12[B_POL1])))
		else $error("buck a control wrong");
	chk_buck_b_level: assert property (1'b1 |=> buck_b_pin_on // see RL15
		== ($past(st.reg3[B_BUCKB2]) && !$past(st.reg12[B_DIR2])
		&& $past(pin_s[1]) == $past(st.reg12[B_POL2])))
		else $error("buck b control wrong");
	chk_standby_level: assert property (1'b1 |=> buck_standby_pin_req // see RL8
		== ($past(st.reg12[B_SBY1]) && !$past(st.reg12[B_DIR1])
		&& $past(pin_s[0]) == $past(st.reg12[B_POL1])))
		else $error("standby control wrong");
	chk_single_event: assert property (ev1 |=> !ev1) // see RL20
		else $error("one transition gave two events");
	chk_aux_switch: assert property (seq_wr3 |=> aux_regulator_enable // see RL11
		== $past(wr_data[B_AUXREG]))
		else $error("auxiliary regulator switch wrong");
	chk_charge_select: assert property (seq_wr3 |=> charge_voltage_select // see RL12
		== $past(wr_data[B_CHGV]))
		else $error("charge voltage select wrong");
	chk_level_mirror: assert property (1'b1 |=> pin_levels == $past(pin_s)) // see RL16
		else $error("pin levels not mirrored");

endmodule : gpc_top

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the pin control block, driven through the two-wire bus.
// Assumes pins and bus are open drain; released pins take the bench's ext levels.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import gpc_pkg::*;

	// ==========================================================
	// Clock, reset and wires
	logic       clk         = 1'b0;
	logic       rstn        = 1'b0;
	logic [2:0] ext         = 3'b111;
	int         miscompares = 0;
	int         checks_done = 0;
	wire logic  scl, sda_m, sda_w, sda_out, sda_oe_n, irq_n;
	wire logic  p1, p2, p3, out1, out2, out3, oe1, oe2, oe3;
	wire logic  buck_a, buck_b, sby, aux, chg;
	wire logic [2:0] lv;

	always #(CLK_PERIOD_NS / 2) clk = ~clk;

	assign sda_w = sda_m & (sda_oe_n | sda_out);
	assign p1    = oe1 ? ext[0] : out1;
	assign p2    = oe2 ? ext[1] : out2;
	assign p3    = oe3 ? ext[2] : out3;

	gpc_top i_dut (
		.clk                   (clk),
		.rstn                  (rstn),
		.scl_in                (scl),
		.sda_in                (sda_w),
		.sda_out               (sda_out),
		.sda_oe_n              (sda_oe_n),
		.gp_pin_one_in         (p1),
		.gp_pin_one_out        (out1),
		.gp_pin_one_oe_n       (oe1),
		.gp_pin_two_in         (p2),
		.gp_pin_two_out        (out2),
		.gp_pin_two_oe_n       (oe2),
		.gp_pin_three_in       (p3),
		.gp_pin_three_out      (out3),
		.gp_pin_three_oe_n     (oe3),
		.irq_n                 (irq_n),
		.buck_a_pin_on         (buck_a),
		.buck_b_pin_on         (buck_b),
		.buck_standby_pin_req  (sby),
		.aux_regulator_enable  (aux),
		.charge_voltage_select (chg),
		.pin_levels            (lv)
	);

	gpc_host_model i_host (
		.clk   (clk),
		.scl   (scl),
		.sda   (sda_m),
		.sda_w (sda_w)
	);

	// ==========================================================
	// Tasks
	task automatic report_and_stop();
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] ptr, dat);
		logic nak;
		i_host.reg_write(I2C_DEV_ADDR, ptr, dat, nak);
		check(8'(nak), 8'h00);
	endtask : wr

	task automatic rd(input logic [7:0] ptr, exp);
		logic [7:0] d;
		logic       nak;
		i_host.reg_read(I2C_DEV_ADDR, ptr, d, nak);
		check(8'(nak), 8'h00);
		check(d, exp);
	endtask : rd

	// The level before the edge is set first, so its own event dies out during the writes
	task automatic irq_case(input logic [7:0] r1b, r1c, input int pin, input logic lvl, exp_irq);
		int cnt = 0;
		ext[pin] = !lvl;
		wr(ADDR_PIN12, r1b);
		wr(ADDR_PIN3, r1c);
		ext[pin] = lvl;
		for (int i = 0; i < 12 && irq_n !== 1'b0; i++)
			@(negedge clk);
		check(8'(irq_n === 1'b0), 8'(exp_irq));
		while (irq_n === 1'b0 && cnt < 300)
		begin
			@(negedge clk);
			cnt++;
		end
		if (exp_irq)
			check(8'(cnt), 8'(INT_PULSE_CYC));
	endtask : irq_case

	// ==========================================================
	// Tests
	logic [7:0] pats [4] = '{8'hA5, 8'h5A, 8'hC0, 8'h3F};
	logic [7:0] p;
	logic       pol;
	logic       nak;

	initial
	begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		repeat (8) @(negedge clk);
		check(8'({irq_n, oe1, oe2, oe3, sda_oe_n, buck_a, buck_b, sby}), 8'hF8);
		rd(ADDR_PIN12, RST_PIN12);
		rd(ADDR_PIN3, RST_PIN3);
		for (int i = 0; i < 4; i++)
		begin
			p = pats[i];
			wr(ADDR_PIN12, p);
			wr(ADDR_PIN3, p);
			rd(ADDR_PIN12, p);
			rd(ADDR_PIN3, p);
			check(8'({oe1, oe2, oe3, aux, chg}), 8'({!(p[6] & !p[4]), !(p[7] & !p[5]),
				!(p[7] & !p[6]), p[5], p[4]}));
			check(8'(lv), 8'({!(p[7] & !p[6]), !(p[7] & !p[5]),
				!(p[6] & !p[4])}));
		end
		wr(8'h1D, 8'h77);
		rd(8'h1D, 8'h00);
		i_host.reg_write(I2C_DEV_ADDR ^ 7'h01, ADDR_PIN12, 8'h00, nak);
		check(8'(nak), 8'h01);
		rd(ADDR_PIN12, 8'h3F);
		wr(ADDR_PIN12, 8'h00);
		wr(ADDR_PIN3, 8'h00);
		for (int v = 0; v < 8; v++)
		begin
			ext = 3'(v);
			repeat (6) @(negedge clk);
			check(8'(lv), 8'(v));
		end
		// Third pass keeps polarity set but enables clear
		for (int c = 0; c < 3; c++)
		begin
			pol = (c != 1);
			wr(ADDR_PIN12, c == 0 ? 8'h0F : (c == 1 ? 8'h03 : 8'h0C));
			wr(ADDR_PIN3, c == 2 ? 8'h00 : 8'h01);
			for (int v = 0; v < 4; v++)
			begin
				ext = 3'(v) | 3'b100;
				repeat (6) @(negedge clk);
				check(8'({buck_a, buck_b, sby}), 8'({3{c != 2}} & {v[0] == pol, v[1] == pol,
					v[0] == pol}));
			end
		end
		irq_case(8'h04, 8'h02, 0, 1'b0, 1'b1);
		irq_case(8'h04, 8'h02, 0, 1'b1, 1'b0);
		irq_case(8'h00, 8'h02, 0, 1'b1, 1'b1);
		irq_case(8'h00, 8'h00, 0, 1'b1, 1'b0);
		irq_case(8'h08, 8'h04, 1, 1'b0, 1'b1);
		irq_case(8'h00, 8'h04, 1, 1'b1, 1'b1);
		irq_case(8'h00, 8'h02, 1, 1'b1, 1'b0);
		irq_case(8'h54, 8'h02, 0, 1'b0, 1'b0);
		report_and_stop();
	end

	// Tests need roughly 105 us; the limit leaves a wide margin
	initial
	begin
		#400000;
		miscompares++;
		report_and_stop();
	end
endmodule : tb

`default_nettype wire
